// ### src/cfcb_defs.svh
// Purpose: Constants for the camera frame capture buffer.
// Assumes: Main clock of 250 MHz; sensor system clock of 8.865 MHz.
// Notes:   Times are kept in their own units; cycle counts derive from them.
`ifndef CFCB_DEFS_SVH
`define CFCB_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and frame timing
// ----------------------------------------------------------------------
`define CFCB_MCLK_NS      4
`define CFCB_CIF_US       11440
`define CFCB_QCIF_US      2860
`define CFCB_LCD_US       2320
`define CFCB_CYC(us)      (((us) * 1000) / `CFCB_MCLK_NS)
`define CFCB_WAIT_FRAMES  2

// ----------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------
`define CFCB_CIF_W        352
`define CFCB_CIF_H        288
`define CFCB_FIFO_DEPTH   32
`define CFCB_PIX_W        8
`define CFCB_PACK_LAST    3'h7
`define CFCB_SYNC_TAPS    3

`endif

// ### src/cfcb_pkg.sv
// Purpose: Types used by the capture buffer, including the word carried through its crossing FIFO.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are one-hot.
package cfcb_pkg;

  // ----------------------------------------------------------------------
  // Word carried from the pixel clock domain to the main clock domain
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       last;
    logic [7:0] y;
  } cfcb_word_type;

  // ----------------------------------------------------------------------
  // State machines
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    CAP_IDLE = 4'h1,
    CAP_ARM  = 4'h2,
    CAP_RUN  = 4'h4,
    CAP_END  = 4'h8
  } cfcb_cap_type;

  typedef enum logic [2:0] {
    WR_IDLE = 3'h1,
    WR_FILL = 3'h2,
    WR_DONE = 3'h4
  } cfcb_wr_type;

endpackage

// ### src/cfcb_fifo.sv
// Purpose: Dual-clock FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two, at least 4.
// Notes:   Gray-coded pointers cross through two flip-flops each.
`timescale 1ns/1ps
module cfcb_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 32
) (
  input  wire logic             i_wclk,
  input  wire logic             i_wrst,
  input  wire logic             i_wvalid,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic                  o_wready,
  input  wire logic             i_rclk,
  input  wire logic             i_rrst,
  output logic                  o_rvalid,
  input  wire logic             i_rready,
  output logic      [WIDTH-1:0] o_rdata
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wbin_q, wbin_d, wgray_q, rg_s1, rg_s2;
  logic [AW:0]      rbin_q, rbin_d, rgray_q, wg_s1, wg_s2;

  function automatic logic [AW:0] to_gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // Full when the write pointer leads by one whole turn.
  assign o_wready = (wgray_q != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
  assign o_rvalid = (rgray_q != wg_s2);
  assign o_rdata  = mem[rbin_q[AW-1:0]];

  // Next pointers advance on each accepted handshake.
  always_comb begin
    wbin_d = wbin_q + (AW+1)'(i_wvalid && o_wready);
    rbin_d = rbin_q + (AW+1)'(o_rvalid && i_rready);
  end

  // Write side: storage, pointer and read-pointer synchroniser.
  always_ff @(posedge i_wclk) begin
    if (i_wvalid && o_wready) begin
      mem[wbin_q[AW-1:0]] <= i_wdata;
    end
    if (i_wrst) begin
      wbin_q  <= '0;
      wgray_q <= '0;
      rg_s1   <= '0;
      rg_s2   <= '0;
    end else begin
      wbin_q  <= wbin_d;
      wgray_q <= to_gray(wbin_d);
      rg_s1   <= rgray_q;
      rg_s2   <= rg_s1;
    end
  end

  // Read side: pointer and write-pointer synchroniser.
  always_ff @(posedge i_rclk) begin
    if (i_rrst) begin
      rbin_q  <= '0;
      rgray_q <= '0;
      wg_s1   <= '0;
      wg_s2   <= '0;
    end else begin
      rbin_q  <= rbin_d;
      rgray_q <= to_gray(rbin_d);
      wg_s1   <= wgray_q;
      wg_s2   <= wg_s1;
    end
  end

endmodule

// ### src/cfcb_top.sv
// Purpose: Camera frame grabber: captures one sensor frame into local RAM
//          and hands it byte by byte to a microcontroller.
// Assumes: Sensor data and frame sync are timed to the pixel clock.
// Notes:   Pixel clock may stop between frames; long counts are parameters.
//
// Summary of operation
// - Each luminance byte is taken on the pixel clock while line valid.
// - After a request made while no frame is streaming, nothing is stored until the next frame sync.
// - Frame-ready rises once the whole frame sits in RAM.
// - Frame-ready comes within two frame periods of the request.
// - A CIF frame takes 11.44 ms, QCIF 2.86 ms, small window 2.32 ms.
// - Each rising read strobe presents the next stored byte.
// - Optionally bytes are thresholded and eight bits packed per byte.
`timescale 1ns/1ps
`include "cfcb_defs.svh"
module cfcb_top #(
  parameter int FRAME_US  = `CFCB_CIF_US,
  parameter int RAM_DEPTH = `CFCB_CIF_W * `CFCB_CIF_H,
  parameter int MAX_WAIT  = `CFCB_WAIT_FRAMES * `CFCB_CYC(FRAME_US)
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_srst,
  input  wire logic                     i_pclk,
  input  wire logic                     i_vsync,
  input  wire logic                     i_href,
  input  wire logic [`CFCB_PIX_W-1:0]   i_pix_y,
  input  wire logic                     i_capture_req,
  input  wire logic                     i_rd_strobe,
  input  wire logic                     i_thr_en,
  input  wire logic [`CFCB_PIX_W-1:0]   i_thr_level,
  output logic                          o_frame_ready,
  output logic      [`CFCB_PIX_W-1:0]   o_rd_data,
  output logic                          o_overflow
);
  import cfcb_pkg::*;

  localparam int AW = $clog2(RAM_DEPTH);
  localparam int CW = $clog2(MAX_WAIT + 2);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [`CFCB_PIX_W-1:0] ram [RAM_DEPTH];

  logic          prst_s1, prst_s2;
  logic [2:0]    arm_s;
  logic          vs_q, vs_rise, arm_ev;
  cfcb_cap_type  cap_q, cap_d;
  logic          ovf_tgl_q, ovf_tgl_d;
  logic          f_wvalid, f_wready;
  cfcb_word_type f_wdata;

  logic [2:0]    req_s, rd_s, ovf_s;
  logic          thr_en_s1, thr_en_s2;
  logic [7:0]    thr_s1, thr_s2;
  logic          req_rise, rd_rise;
  cfcb_wr_type   wr_q, wr_d;
  logic          arm_tgl_q, arm_tgl_d;
  logic [AW-1:0] wr_addr_q, wr_addr_d, rd_addr_q, rd_addr_d;
  logic [7:0]    pack_q, pack_d;
  logic [2:0]    bit_q, bit_d;
  logic          ready_q, ready_d, ovf_q, ovf_d;
  logic [CW-1:0] wait_q, wait_d;
  logic          f_rvalid, f_rready, pop, wr_en;
  cfcb_word_type f_rdata;
  logic [7:0]    wr_data;

  function automatic logic [AW-1:0] addr_inc(input logic [AW-1:0] a);
    return (a == AW'(RAM_DEPTH - 1)) ? '0 : a + 1'b1;
  endfunction

  // ----------------------------------------------------------------------
  // Pixel clock domain
  // ----------------------------------------------------------------------

  // Reset and the arm toggle cross into the pixel clock through two stages.
  always_ff @(posedge i_pclk) begin
    prst_s1 <= i_srst;
    prst_s2 <= prst_s1;
    arm_s   <= {arm_s[1:0], arm_tgl_q};
  end

  assign vs_rise = i_vsync && !vs_q;
  assign arm_ev  = arm_s[2] ^ arm_s[1];

  // Capture sequencer: arm, wait for frame start, stream, mark the end.
  always_comb begin
    cap_d     = cap_q;
    ovf_tgl_d = ovf_tgl_q;
    f_wvalid  = 1'b0;
    f_wdata   = '{last: 1'b0, y: i_pix_y};
    unique case (cap_q)
      CAP_IDLE: begin
        if (arm_ev) cap_d = CAP_ARM;
      end
      CAP_ARM: begin
        if (vs_rise) cap_d = CAP_RUN;
      end
      CAP_RUN: begin
        if (arm_ev) begin
          cap_d = CAP_ARM;
        end else if (vs_rise) begin
          cap_d = CAP_END;
        end else if (i_href) begin
          f_wvalid = 1'b1;
          if (!f_wready) ovf_tgl_d = !ovf_tgl_q;
        end
      end
      CAP_END: begin
        f_wvalid = 1'b1;
        f_wdata  = '{last: 1'b1, y: '0};
        if (arm_ev) cap_d = CAP_ARM;
        else if (f_wready) cap_d = CAP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_pclk) begin
    if (prst_s2) begin
      cap_q     <= CAP_IDLE;
      vs_q      <= 1'b0;
      ovf_tgl_q <= 1'b0;
    end else begin
      cap_q     <= cap_d;
      vs_q      <= i_vsync;
      ovf_tgl_q <= ovf_tgl_d;
    end
  end

  // ----------------------------------------------------------------------
  // Crossing buffer
  // ----------------------------------------------------------------------
  cfcb_fifo #(
    .WIDTH ($bits(cfcb_word_type)),
    .DEPTH (`CFCB_FIFO_DEPTH)
  ) u_fifo (
    .i_wclk   (i_pclk),
    .i_wrst   (prst_s2),
    .i_wvalid (f_wvalid),
    .i_wdata  (f_wdata),
    .o_wready (f_wready),
    .i_rclk   (i_mclk),
    .i_rrst   (i_srst),
    .o_rvalid (f_rvalid),
    .i_rready (f_rready),
    .o_rdata  (f_rdata)
  );

  // ----------------------------------------------------------------------
  // Main clock domain
  // ----------------------------------------------------------------------

  // Controller pins and switches pass two flops before use.
  always_ff @(posedge i_mclk) begin
    req_s     <= {req_s[1:0], i_capture_req};
    rd_s      <= {rd_s[1:0], i_rd_strobe};
    ovf_s     <= {ovf_s[1:0], ovf_tgl_q};
    thr_en_s1 <= i_thr_en;
    thr_en_s2 <= thr_en_s1;
    thr_s1    <= i_thr_level;
    thr_s2    <= thr_s1;
  end

  assign req_rise = req_s[1] && !req_s[2];
  assign rd_rise  = rd_s[1] && !rd_s[2];

  // The FIFO drains only while filling; otherwise it back-pressures.
  assign f_rready = (wr_q == WR_FILL);
  assign pop      = f_rvalid && f_rready;

  // Frame writer, read pointer and frame-ready flag.
  always_comb begin
    wr_d      = wr_q;
    arm_tgl_d = arm_tgl_q;
    wr_addr_d = wr_addr_q;
    rd_addr_d = rd_addr_q;
    pack_d    = pack_q;
    bit_d     = bit_q;
    ready_d   = ready_q;
    ovf_d     = ovf_q || (ovf_s[2] ^ ovf_s[1]);
    wait_d    = (wr_q == WR_FILL && wait_q != '1) ? wait_q + 1'b1 : wait_q;
    wr_en     = 1'b0;
    wr_data   = f_rdata.y;
    if (rd_rise) rd_addr_d = addr_inc(rd_addr_q);
    unique case (wr_q)
      WR_IDLE, WR_DONE: ;
      WR_FILL: begin
        if (pop && f_rdata.last) begin
          wr_d    = WR_DONE;
          ready_d = 1'b1;
        end else if (pop && thr_en_s2) begin
          pack_d = {pack_q[6:0], f_rdata.y >= thr_s2};
          bit_d  = bit_q + 1'b1;
          if (bit_q == `CFCB_PACK_LAST) begin
            wr_en     = 1'b1;
            wr_data   = pack_d;
            wr_addr_d = addr_inc(wr_addr_q);
          end
        end else if (pop) begin
          wr_en     = 1'b1;
          wr_addr_d = addr_inc(wr_addr_q);
        end
      end
    endcase
    if (req_rise) begin
      wr_d      = WR_FILL;
      arm_tgl_d = !arm_tgl_q;
      wr_addr_d = '0;
      rd_addr_d = '0;
      ready_d   = 1'b0;
      bit_d     = '0;
      wait_d    = '0;
      ovf_d     = ovf_s[2] ^ ovf_s[1]; // A drop seen now still sets.
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wr_q      <= WR_IDLE;
      arm_tgl_q <= 1'b0;
      wr_addr_q <= '0;
      rd_addr_q <= '0;
      pack_q    <= '0;
      bit_q     <= '0;
      ready_q   <= 1'b0;
      ovf_q     <= 1'b0;
      wait_q    <= '0;
    end else begin
      wr_q      <= wr_d;
      arm_tgl_q <= arm_tgl_d;
      wr_addr_q <= wr_addr_d;
      rd_addr_q <= rd_addr_d;
      pack_q    <= pack_d;
      bit_q     <= bit_d;
      ready_q   <= ready_d;
      ovf_q     <= ovf_d;
      wait_q    <= wait_d;
    end
  end

  // Frame RAM write port and strobe-driven read port.
  always_ff @(posedge i_mclk) begin
    if (wr_en) ram[wr_addr_q] <= wr_data;
    if (i_srst) begin
      o_rd_data <= '0;
    end else if (rd_rise) begin
      o_rd_data <= ram[rd_addr_q];
    end
  end

  // Flags leave through their own registers.
  assign o_frame_ready = ready_q;
  assign o_overflow    = ovf_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  sequence s_req_taken;
    req_rise;
  endsequence

  sequence s_cleared;
    !o_frame_ready && wr_addr_q == '0 && rd_addr_q == '0;
  endsequence

  sequence s_last_pop;
    pop && f_rdata.last;
  endsequence

  // Request side: clearing, arming and the two-stage synchroniser.
  a_req_clears_all: assert property (s_req_taken |=> s_cleared)
    else $error("Request did not clear addresses and frame-ready.");

  a_req_arms: assert property (s_req_taken
    |=> arm_tgl_q != $past(arm_tgl_q))
    else $error("Request did not arm the pixel side.");

  a_req_sync: assert property ($past(i_capture_req, 2)
    && !$past(i_capture_req, 3) |-> req_rise)
    else $error("Request edge not seen after two stages.");

  // Frame-ready: its cause, its holding and its time limit.
  a_ready_on_last: assert property (s_last_pop ##0 !req_rise
    |=> o_frame_ready)
    else $error("Frame-ready did not rise after the last word.");

  a_ready_cause: assert property ($rose(o_frame_ready)
    |-> $past(pop) && $past(f_rdata.last))
    else $error("Frame-ready rose without a stored frame.");

  a_ready_holds: assert property (o_frame_ready && !req_rise
    |=> o_frame_ready)
    else $error("Frame-ready fell without a new request.");

  a_fill_not_ready: assert property (wr_q == WR_FILL
    |-> !o_frame_ready)
    else $error("Frame-ready high while the frame is still filling.");

  a_wait_bound: assert property (wr_q == WR_FILL
    |-> wait_q <= CW'(MAX_WAIT))
    else $error("Frame-ready later than two frame periods.");

  // Read port and packing.
  a_read_advance: assert property (rd_rise && !req_rise
    |=> rd_addr_q == addr_inc($past(rd_addr_q)))
    else $error("Read address did not step on the strobe.");

  a_read_data: assert property (rd_rise && !wr_en
    |=> o_rd_data == ram[$past(rd_addr_q)])
    else $error("Read data is not the addressed byte.");

  a_strobe_sync: assert property ($rose(i_rd_strobe) && !req_rise
    ##1 i_rd_strobe |-> ##[1:2] rd_rise)
    else $error("Read strobe edge not seen after two stages.");

  a_pack_eight: assert property (wr_en && thr_en_s2
    |-> bit_q == `CFCB_PACK_LAST)
    else $error("Packed byte written before eight bits.");

  // Pixel clock side: arming, frame boundaries and byte capture.
  a_no_early_pix: assert property (@(posedge i_pclk)
    disable iff (prst_s2) cap_q == CAP_ARM |-> !f_wvalid)
    else $error("Pixel pushed before frame start.");

  a_arm_holds: assert property (@(posedge i_pclk)
    disable iff (prst_s2) cap_q == CAP_ARM && !vs_rise |=> cap_q == CAP_ARM)
    else $error("Capture left arming without a frame start.");

  a_frame_end: assert property (@(posedge i_pclk)
    disable iff (prst_s2) cap_q == CAP_RUN && vs_rise && !arm_ev
    |=> cap_q == CAP_END)
    else $error("Frame sync did not close the capture.");

  a_pix_taken: assert property (@(posedge i_pclk)
    disable iff (prst_s2) cap_q == CAP_RUN && i_href && !vs_rise && !arm_ev
    |-> f_wvalid && f_wdata.y == i_pix_y)
    else $error("Pixel byte not taken on the pixel clock.");

endmodule

// ### verif/cfcb_sensor_model.sv
// Purpose: Behavioural image sensor driving the pixel side of the grabber.
// Assumes: A pixel clock period of 48 ns; data changes while the clock is low.
// Notes:   The pixel clock stands still outside the task calls.
`timescale 1ns/1ps
module cfcb_sensor_model (
  output logic       o_pclk,
  output logic       o_vsync,
  output logic       o_href,
  output logic [7:0] o_pix_y
);
  // ----------------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------------
  // The lines start low and the clock stays stopped until a task runs it.
  // The sensor is taken as already set up over its slow serial control bus.
  initial begin
    o_pclk  = 1'b0;
    o_vsync = 1'b0;
    o_href  = 1'b0;
    o_pix_y = 8'h00;
  end

  // ----------------------------------------------------------------------
  // Link primitives
  // ----------------------------------------------------------------------
  // One pixel clock period; values set before it are sampled on its rise.
  task automatic tick();
    #24 o_pclk = 1'b1;
    #24 o_pclk = 1'b0;
  endtask

  // Blanking: no line valid, and the data bus toggles so nothing stale shows.
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      o_href  = 1'b0;
      o_pix_y = ~o_pix_y;
      tick();
    end
  endtask

  // Frame sync pulse; its rising edge marks a frame boundary.
  task automatic frame_sync();
    o_vsync = 1'b1;
    tick();
    tick();
    o_vsync = 1'b0;
    tick();
  endtask

  // Lines of bytes counting up from base, one byte per clock.
  task automatic lines(input int n, input int w, input logic [7:0] base);
    int idx;
    idx = 0;
    for (int l = 0; l < n; l++) begin
      for (int p = 0; p < w; p++) begin
        o_href  = 1'b1;
        o_pix_y = base + 8'(idx);
        idx++;
        tick();
      end
      idle(2);
    end
  endtask
endmodule

// ### verif/cfcb_top_tb.sv
// Purpose: Self-checking bench for the camera frame capture buffer.
// Assumes: Small frames of 4 lines of 8 bytes and a RAM of 64 bytes.
// Notes:   Controller signals are driven on the falling main clock edge.
`timescale 1ns/1ps
module cfcb_top_tb;
  import cfcb_pkg::*;

  // ----------------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------------
  localparam int RAM_DEPTH = 64;
  localparam int MAX_WAIT  = 3000;
  localparam int LINES     = 4;
  localparam int WIDTH     = 8;
  localparam int NPIX      = LINES * WIDTH;

  logic       i_mclk        = 1'b0;
  logic       i_srst        = 1'b1;
  logic       i_capture_req = 1'b0;
  logic       i_rd_strobe   = 1'b0;
  logic       i_thr_en      = 1'b0;
  logic [7:0] i_thr_level   = 8'h10;
  logic       pclk;
  logic       vsync;
  logic       href;
  logic [7:0] pix_y;
  logic       o_frame_ready;
  logic [7:0] o_rd_data;
  logic       o_overflow;
  int         n_errors      = 0;
  int         n_tests       = 0;
  int         cyc           = 0;
  int         t_req         = 0;

  // The main clock runs at 250 MHz; a cycle counter times the requests.
  always #2 i_mclk = ~i_mclk;
  always @(posedge i_mclk) cyc <= cyc + 1;

  cfcb_sensor_model i_sensor (
    .o_pclk  (pclk),
    .o_vsync (vsync),
    .o_href  (href),
    .o_pix_y (pix_y)
  );

  cfcb_top #(
    .RAM_DEPTH (RAM_DEPTH),
    .MAX_WAIT  (MAX_WAIT)
  ) i_dut (
    .i_mclk        (i_mclk),
    .i_srst        (i_srst),
    .i_pclk        (pclk),
    .i_vsync       (vsync),
    .i_href        (href),
    .i_pix_y       (pix_y),
    .i_capture_req (i_capture_req),
    .i_rd_strobe   (i_rd_strobe),
    .i_thr_en      (i_thr_en),
    .i_thr_level   (i_thr_level),
    .o_frame_ready (o_frame_ready),
    .o_rd_data     (o_rd_data),
    .o_overflow    (o_overflow)
  );

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  // Prints the counts and the verdict, then stops the run.
  task automatic finish_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
      n_errors++;
    end
  endtask

  task automatic mclk(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  // A request pulse held well past the synchroniser on both levels.
  task automatic request();
    mclk(1);
    i_capture_req = 1'b1;
    t_req = cyc;
    mclk(4);
    i_capture_req = 1'b0;
    mclk(4);
  endtask

  // One read strobe; the fetched byte has settled when the task returns.
  task automatic strobe();
    i_rd_strobe = 1'b1;
    mclk(4);
    i_rd_strobe = 1'b0;
    mclk(4);
  endtask

  // Bounded wait for frame-ready, then a check of the time since request.
  task automatic wait_ready();
    int k;
    k = 0;
    while (k < MAX_WAIT && o_frame_ready !== 1'b1) begin
      mclk(1);
      k++;
    end
    if (k >= MAX_WAIT) begin
      n_errors++;
      finish_test();
    end
    chk_bit(cyc - t_req <= MAX_WAIT, 1'b1);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset levels of all outputs.
  task automatic t_reset();
    chk_bit(o_frame_ready, 1'b0);
    chk_byte(o_rd_data, 8'h00);
    chk_bit(o_overflow, 1'b0);
  endtask

  // Request a frame; optionally bytes arrive before the next frame sync.
  task automatic t_capture(input logic [7:0] base, input bit skip);
    request();
    chk_bit(o_frame_ready, 1'b0);
    i_sensor.idle(6);
    if (skip) begin
      i_sensor.lines(2, WIDTH, 8'h80);
    end
    i_sensor.frame_sync();
    i_sensor.lines(LINES, WIDTH, base);
    mclk(10);
    chk_bit(o_frame_ready, 1'b0);
    i_sensor.frame_sync();
    i_sensor.idle(8);
    wait_ready();
  endtask

  // Read n bytes back and expect the counting pattern from base.
  task automatic t_read(input logic [7:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      strobe();
      chk_byte(o_rd_data, base + 8'(i));
    end
  endtask

  // Threshold mode: each byte packs eight compare results, first in bit 7.
  task automatic t_thresh(input logic [7:0] base, input logic [7:0] lvl);
    logic [7:0] p;
    logic [7:0] e;
    i_thr_en    = 1'b1;
    i_thr_level = lvl;
    t_capture(base, 1'b0);
    for (int g = 0; g < NPIX / 8; g++) begin
      for (int b = 0; b < 8; b++) begin
        p        = base + 8'(g * 8 + b);
        e[7 - b] = (p >= lvl);
      end
      strobe();
      chk_byte(o_rd_data, e);
    end
    i_thr_en = 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  // Reset is held while the pixel clock also runs, then scenarios follow.
  initial begin
    fork
      mclk(20);
      i_sensor.idle(4);
    join
    t_reset();
    i_srst = 1'b0;
    i_sensor.idle(4);
    t_capture(8'h20, 1'b1);
    t_read(8'h20, NPIX);
    chk_bit(o_overflow, 1'b0);
    t_capture(8'h40, 1'b0);
    t_read(8'h40, 3);
    t_capture(8'h60, 1'b0);
    t_read(8'h60, 4);
    t_thresh(8'h0c, 8'h10);
    finish_test();
  end
endmodule
